/* File: inc/lcd_timing_pkg.sv */
// Purpose: Shared constants and types for the LCD panel timing block
// Assumes: 32-bit classic Wishbone register bus, byte addressed
// Notes:   Horizontal and vertical timing words share one field layout

package lcd_timing_pkg;

    // --------------------------------------------------------------
    // Register offsets
    // --------------------------------------------------------------
    localparam logic [7:0]  OFFSET_CONTROL  = 8'h00;
    localparam logic [7:0]  OFFSET_STATUS   = 8'h04;
    localparam logic [7:0]  OFFSET_HORIZ    = 8'h0C;
    localparam logic [7:0]  OFFSET_VERT     = 8'h10;
    localparam logic [7:0]  OFFSET_CLOCK    = 8'h14;

    // --------------------------------------------------------------
    // Reset values and masks
    // --------------------------------------------------------------
    localparam logic [31:0] RESET_WORD      = 32'h0000_0000;
    localparam logic [31:0] CONTROL_MASK    = 32'h0000_0003;
    localparam logic [31:0] CLOCK_MASK      = 32'h000F_FFFF;

    // --------------------------------------------------------------
    // Field positions
    // --------------------------------------------------------------
    localparam int          CTRL_GO_BIT     = 0;
    localparam int          CTRL_TFT_BIT    = 1;
    localparam int          STAT_BUSY_BIT   = 0;
    localparam int          STAT_SHUT_BIT   = 7;
    localparam int          STAT_ROW_LSB    = 16;
    localparam int          STAT_ROW_MSB    = 25;

    // --------------------------------------------------------------
    // Field layouts
    // --------------------------------------------------------------
    typedef struct packed {
        logic [7:0] porch_second;
        logic [7:0] porch_first;
        logic [5:0] sync_width;
        logic [9:0] active_count;
    } span_timing_type;

    typedef struct packed {
        logic [11:0] reserved;
        logic        pixel_divider_bypass;
        logic        bias_polarity_invert;
        logic        pixel_clock_edge_invert;
        logic        line_clock_invert;
        logic        frame_clock_invert;
        logic [4:0]  bias_toggle_interval;
        logic [9:0]  pixel_clock_divider;
    } clock_control_type;

    typedef struct packed {
        logic line_clock;
        logic frame_clock;
        logic bias;
        logic data_enable;
    } panel_pins_type;

    // --------------------------------------------------------------
    // State encodings
    // --------------------------------------------------------------
    typedef enum logic [3:0] {
        PHASE_ACTIVE       = 4'h1,
        PHASE_PORCH_FIRST  = 4'h2,
        PHASE_SYNC         = 4'h4,
        PHASE_PORCH_SECOND = 4'h8
    } phase_type;

    typedef enum logic [1:0] {
        RUN_IDLE   = 2'h1,
        RUN_ACTIVE = 2'h2
    } run_state_type;

endpackage : lcd_timing_pkg

/* File: src/lcd_panel_timing_clock_gen.sv */
// Purpose: Line and frame timing plus pixel clock for an STN or TFT panel
// Assumes: Classic Wishbone slave, 32-bit data, byte addresses
// Notes:   Timing and clock words accept writes only while stopped
//
// How it works
// - Second horizontal porch comes from bits 31:24, length is value plus one.
// - First horizontal porch comes from bits 23:16, length is value plus one.
// - Line sync pulse width is bits 15:10 plus one pixels.
// - Active pixels per line equal bits 9:0 plus one.
// - Second vertical porch is bits 31:24 plus one lines, skipped for STN.
// - First vertical porch is bits 23:16 plus one lines.
// - Frame sync is bits 15:10 plus one lines, unused for STN.
// - Active lines per panel equal bits 9:0 plus one.
// - Bit 19 clear divides the pixel clock, set runs it at clk.
// - Bit 18 set inverts the bias output.
// - Bit 17 chooses rising or falling launch edge of pixel clock.
// - Bit 16 inverts line clock, bit 15 inverts frame clock.
// - STN bias toggles every bits 14:10 plus one line clocks.
// - Divided pixel clock is clk over two times (divisor plus one).
// - Timing and clock registers change only once stopped, shown by a clear busy flag (status bit 0).
//
// The Wishbone register port was decided locally.

`timescale 1ns/1ps

module lcd_panel_timing_clock_gen #(
    parameter int ADDR_WIDTH = 8
) (
    input  wire logic                          clk,
    input  wire logic                          rst_n,
    input  wire logic                          wb_cyc_i,
    input  wire logic                          wb_stb_i,
    input  wire logic                          wb_we_i,
    input  wire logic [ADDR_WIDTH-1:0]         wb_adr_i,
    input  wire logic [3:0]                    wb_sel_i,
    input  wire logic [31:0]                   wb_dat_i,
    output logic      [31:0]                   wb_dat_o,
    output logic                               wb_ack_o,
    output lcd_timing_pkg::panel_pins_type     panel_pins,
    output logic                               pixel_clock,
    output logic                               pixel_launch
);
    import lcd_timing_pkg::*;
    if (ADDR_WIDTH < 8) begin : bad_addr
        $error("ADDR_WIDTH must be at least 8");
    end

    // --------------------------------------------------------------
    // Register state
    // --------------------------------------------------------------
    logic [31:0]       control_reg;
    span_timing_type   horiz_reg;
    span_timing_type   vert_reg;
    clock_control_type clock_reg;
    logic              shutdown_reg;
    logic              ack_reg;
    logic [31:0]       rdata_reg;
    run_state_type     run_state_reg;
    run_state_type     run_state_next;
    phase_type         h_phase_reg;
    phase_type         h_phase_next;
    phase_type         v_phase_reg;
    phase_type         v_phase_next;
    logic [9:0]        h_count_reg;
    logic [9:0]        h_count_next;
    logic [9:0]        v_count_reg;
    logic [9:0]        v_count_next;
    logic [9:0]        row_reg;
    logic [9:0]        row_next;
    logic [4:0]        bias_count_reg;
    logic              bias_level_reg;
    panel_pins_type    pins_reg;
    panel_pins_type    pins_next;

    // --------------------------------------------------------------
    // Bus decode
    // --------------------------------------------------------------
    wire        bus_req      = wb_cyc_i && wb_stb_i;
    wire        bus_take     = bus_req && !ack_reg;
    wire        bus_write    = bus_take && wb_we_i;
    wire [7:0]  adr_low      = wb_adr_i[7:0];
    wire        adr_high_ok  = (wb_adr_i >> 8) == '0;
    wire        hit_control  = adr_high_ok && (adr_low == OFFSET_CONTROL);
    wire        hit_status   = adr_high_ok && (adr_low == OFFSET_STATUS);
    wire        hit_horiz    = adr_high_ok && (adr_low == OFFSET_HORIZ);
    wire        hit_vert     = adr_high_ok && (adr_low == OFFSET_VERT);
    wire        hit_clock    = adr_high_ok && (adr_low == OFFSET_CLOCK);
    wire        stopped      = (run_state_reg == RUN_IDLE);
    wire        timing_open  = bus_write && stopped;
    wire [31:0] lane_mask    = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
                                {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

    function automatic logic [31:0] merge(input logic [31:0] old_word,
                                          input logic [31:0] new_word,
                                          input logic [31:0] mask);
        merge = (old_word & ~mask) | (new_word & mask);
    endfunction : merge
    wire [31:0] control_write = merge(control_reg, wb_dat_i, lane_mask) & CONTROL_MASK;
    wire [31:0] horiz_write   = merge(horiz_reg, wb_dat_i, lane_mask);
    wire [31:0] vert_write    = merge(vert_reg, wb_dat_i, lane_mask);
    wire [31:0] clock_write   = merge(clock_reg, wb_dat_i, lane_mask) & CLOCK_MASK;
    wire        go           = control_reg[CTRL_GO_BIT];
    wire        tft_mode     = control_reg[CTRL_TFT_BIT];
    wire        shut_clear   = bus_write && hit_status && wb_sel_i[0]
                               && wb_dat_i[STAT_SHUT_BIT];
    logic [31:0] status_word;
    always_comb
    begin
        status_word = RESET_WORD;
        status_word[STAT_BUSY_BIT] = !stopped;
        status_word[STAT_SHUT_BIT] = shutdown_reg;
        status_word[STAT_ROW_MSB:STAT_ROW_LSB] = row_reg;
    end
    wire [31:0] read_value = hit_control ? control_reg :
                             hit_status  ? status_word :
                             hit_horiz   ? 32'(horiz_reg) :
                             hit_vert    ? 32'(vert_reg) :
                             hit_clock   ? 32'(clock_reg) :
                                           RESET_WORD;

    // --------------------------------------------------------------
    // Bus registers
    // --------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            ack_reg   <= 1'b0;
            rdata_reg <= RESET_WORD;
        end
        else
        begin
            ack_reg   <= bus_take;
            rdata_reg <= bus_take ? read_value : rdata_reg;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            control_reg <= RESET_WORD;
            horiz_reg   <= RESET_WORD;
            vert_reg    <= RESET_WORD;
            clock_reg   <= RESET_WORD;
        end
        else
        begin
            if (bus_write && hit_control)
                control_reg <= control_write;
            if (timing_open && hit_horiz)
                horiz_reg <= horiz_write;
            if (timing_open && hit_vert)
                vert_reg <= vert_write;
            if (timing_open && hit_clock)
                clock_reg <= clock_write;
        end
    end
    assign wb_ack_o = ack_reg;
    assign wb_dat_o = rdata_reg;

    // --------------------------------------------------------------
    // Pixel clock
    // --------------------------------------------------------------
    wire running = (run_state_reg == RUN_ACTIVE);
    wire tick;
    pixel_clock_divider #(
        .DIV_WIDTH   (10)
    ) u_divider (
        .clk         (clk),
        .rst_n       (rst_n),
        .run         (running),
        .bypass      (clock_reg.pixel_divider_bypass),
        .edge_invert (clock_reg.pixel_clock_edge_invert),
        .divisor     (clock_reg.pixel_clock_divider),
        .launch_tick (tick),
        .pixel_clock (pixel_clock)
    );

    // --------------------------------------------------------------
    // Horizontal sequencing
    // --------------------------------------------------------------
    function automatic phase_type advance(input phase_type phase, input logic short_cycle);
        unique case (phase)
            PHASE_ACTIVE:       advance = PHASE_PORCH_FIRST;
            PHASE_PORCH_FIRST:  advance = short_cycle ? PHASE_ACTIVE : PHASE_SYNC;
            PHASE_SYNC:         advance = PHASE_PORCH_SECOND;
            PHASE_PORCH_SECOND: advance = PHASE_ACTIVE;
            default:            advance = PHASE_ACTIVE;
        endcase
    endfunction : advance
    function automatic logic [9:0] limit(input phase_type phase, input span_timing_type t);
        unique case (phase)
            PHASE_ACTIVE:       limit = t.active_count;
            PHASE_PORCH_FIRST:  limit = {2'h0, t.porch_first};
            PHASE_SYNC:         limit = {4'h0, t.sync_width};
            PHASE_PORCH_SECOND: limit = {2'h0, t.porch_second};
            default:            limit = t.active_count;
        endcase
    endfunction : limit
    // Each count runs 0..field, so every span lasts field plus one
    wire h_last   = (h_count_reg == limit(h_phase_reg, horiz_reg));
    wire line_end = tick && h_last && (h_phase_reg == PHASE_PORCH_SECOND);

    always_comb
    begin
        h_phase_next = h_phase_reg;
        h_count_next = h_count_reg;
        if (!running)
        begin
            h_phase_next = PHASE_ACTIVE;
            h_count_next = 10'h000;
        end
        else if (tick && h_last)
        begin
            h_phase_next = advance(h_phase_reg, 1'b0);
            h_count_next = 10'h000;
        end
        else if (tick)
        begin
            h_count_next = h_count_reg + 10'h001;
        end
    end

    // --------------------------------------------------------------
    // Vertical sequencing
    // --------------------------------------------------------------
    // STN retrace is the first porch alone: sync and second porch skipped
    wire stn_mode  = !tft_mode;
    wire v_last    = (v_count_reg == limit(v_phase_reg, vert_reg));
    wire v_final   = stn_mode ? (v_phase_reg == PHASE_PORCH_FIRST)
                              : (v_phase_reg == PHASE_PORCH_SECOND);
    wire frame_end = line_end && v_last && v_final;

    always_comb
    begin
        v_phase_next = v_phase_reg;
        v_count_next = v_count_reg;
        row_next     = row_reg;
        if (!running)
        begin
            v_phase_next = PHASE_ACTIVE;
            v_count_next = 10'h000;
            row_next     = 10'h000;
        end
        else if (line_end && v_last)
        begin
            v_phase_next = advance(v_phase_reg, stn_mode);
            v_count_next = 10'h000;
            row_next     = frame_end ? 10'h000 : row_reg + 10'h001;
        end
        else if (line_end)
        begin
            v_count_next = v_count_reg + 10'h001;
            row_next     = row_reg + 10'h001;
        end
    end

    // --------------------------------------------------------------
    // Run control
    // --------------------------------------------------------------
    // A cleared go bit lets the current frame finish before stopping
    always_comb
    begin
        run_state_next = run_state_reg;
        unique case (run_state_reg)
            RUN_IDLE:
                if (go)
                    run_state_next = RUN_ACTIVE;
            RUN_ACTIVE:
                if (frame_end && !go)
                    run_state_next = RUN_IDLE;
            default:
                run_state_next = RUN_IDLE;
        endcase
    end
    wire shut_set = running && frame_end && !go;

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            run_state_reg <= RUN_IDLE;
            shutdown_reg  <= 1'b0;
        end
        else
        begin
            run_state_reg <= run_state_next;
            shutdown_reg  <= shut_set || (shutdown_reg && !shut_clear);
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            h_phase_reg <= PHASE_ACTIVE;
            h_count_reg <= 10'h000;
            v_phase_reg <= PHASE_ACTIVE;
            v_count_reg <= 10'h000;
            row_reg     <= 10'h000;
        end
        else
        begin
            h_phase_reg <= h_phase_next;
            h_count_reg <= h_count_next;
            v_phase_reg <= v_phase_next;
            v_count_reg <= v_count_next;
            row_reg     <= row_next;
        end
    end

    // --------------------------------------------------------------
    // Bias toggle
    // --------------------------------------------------------------
    wire bias_wrap = (bias_count_reg == clock_reg.bias_toggle_interval);
    always_ff @(posedge clk)
    begin
        if (!rst_n || !running || tft_mode)
        begin
            bias_count_reg <= 5'h00;
            bias_level_reg <= 1'b0;
        end
        else if (line_end && bias_wrap)
        begin
            bias_count_reg <= 5'h00;
            bias_level_reg <= ~bias_level_reg;
        end
        else if (line_end)
        begin
            bias_count_reg <= bias_count_reg + 5'h01;
        end
    end

    // --------------------------------------------------------------
    // Panel pins
    // --------------------------------------------------------------
    // Pins follow the next state; a stopping frame goes straight to idle
    wire live       = running && (run_state_next == RUN_ACTIVE);
    wire line_sync  = live && (h_phase_next == PHASE_SYNC);
    wire frame_sync = live && (stn_mode ?
                      (v_phase_next == PHASE_PORCH_FIRST && v_count_next == 10'h000) :
                      (v_phase_next == PHASE_SYNC));

    always_comb
    begin
        pins_next.line_clock  = line_sync ^ clock_reg.line_clock_invert;
        pins_next.frame_clock = frame_sync ^ clock_reg.frame_clock_invert;
        pins_next.bias        = bias_level_reg ^ clock_reg.bias_polarity_invert;
        pins_next.data_enable = live && (h_phase_next == PHASE_ACTIVE)
                                && (v_phase_next == PHASE_ACTIVE);
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
            pins_reg <= '0;
        else if (tick || !running)
            pins_reg <= pins_next;
    end
    assign panel_pins   = pins_reg;
    assign pixel_launch = tick;

endmodule : lcd_panel_timing_clock_gen

/* File: src/pixel_clock_divider.sv */
// Purpose: Pixel clock divider and launch tick generator
// Assumes: divisor is stable while run is high
// Notes:   In bypass the pin clock is the system clock, inverted when edge_invert is set, gated by run

`timescale 1ns/1ps

module pixel_clock_divider #(
    parameter int DIV_WIDTH = 10
) (
    input  wire logic                 clk,
    input  wire logic                 rst_n,
    input  wire logic                 run,
    input  wire logic                 bypass,
    input  wire logic                 edge_invert,
    input  wire logic [DIV_WIDTH-1:0] divisor,
    output logic                      launch_tick,
    output logic                      pixel_clock
);

    // --------------------------------------------------------------
    // Half period counter
    // --------------------------------------------------------------
    logic [DIV_WIDTH-1:0] count_reg;
    logic                 level_reg;
    wire                  wrap = (count_reg == divisor);

    if (DIV_WIDTH < 1) begin : bad_width
        $error("DIV_WIDTH must be at least 1");
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n || !run || bypass)
        begin
            count_reg <= '0;
            level_reg <= 1'b0;
        end
        else if (wrap)
        begin
            count_reg <= '0;
            level_reg <= ~level_reg;
        end
        else
        begin
            count_reg <= count_reg + 1'b1;
        end
    end

    // Launch on the rising pin edge, or the falling one when inverted
    wire divided_tick = wrap && (level_reg == edge_invert);

    assign launch_tick = run && (bypass || divided_tick);
    // Bypass: data moves on clk rising, so inverting clk moves launch to falling
    assign pixel_clock = run && (bypass ? (clk ^ edge_invert) : level_reg);

endmodule : pixel_clock_divider

/* File: tb/lcd_panel_timing_chk.sv */
// Purpose: Port assertions for the panel timing block
// Assumes: Clock word is written only while stopped
// Notes:   Clock word is shadowed from taken bus writes
`timescale 1ns/1ps
module lcd_panel_timing_chk #(
    parameter int ADDR_WIDTH = 8
) (
    input wire logic                  clk,
    input wire logic                  rst_n,
    input wire logic                  wb_cyc_i,
    input wire logic                  wb_stb_i,
    input wire logic                  wb_we_i,
    input wire logic [ADDR_WIDTH-1:0] wb_adr_i,
    input wire logic [31:0]           wb_dat_i,
    input wire logic [31:0]           wb_dat_o,
    input wire logic                  wb_ack_o,
    input wire lcd_timing_pkg::panel_pins_type panel_pins,
    input wire logic                  pixel_clock,
    input wire logic                  pixel_launch
);
    import lcd_timing_pkg::*;
    logic [31:0] cw_reg;
    logic [10:0] since_reg;
    wire taken = wb_cyc_i && wb_stb_i && !wb_ack_o;
    wire hit = wb_adr_i inside {ADDR_WIDTH'(OFFSET_CONTROL), ADDR_WIDTH'(OFFSET_STATUS),
        ADDR_WIDTH'(OFFSET_HORIZ), ADDR_WIDTH'(OFFSET_VERT), ADDR_WIDTH'(OFFSET_CLOCK)};
    wire de = panel_pins.data_enable;
    wire div_tick = !cw_reg[19] && pixel_launch && de;
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            cw_reg <= '0;
        else if (taken && wb_we_i && wb_adr_i == ADDR_WIDTH'(OFFSET_CLOCK))
            cw_reg <= wb_dat_i;
    end
    // Read only while pixels are active
    always_ff @(posedge clk)
        since_reg <= pixel_launch ? 11'h000 : since_reg + 11'h001;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    a_ack_once: assert property (taken |=> wb_ack_o ##1 !wb_ack_o)
        else $error("ack not a single pulse after request");
    a_no_stray: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
        else $error("ack without request");
    a_unmapped_zero: assert property (taken && !wb_we_i && !hit |=> wb_dat_o == 32'h0)
        else $error("unmapped read not zero");
    a_de_launch: assert property ($rose(de) |-> $past(pixel_launch))
        else $error("data enable rose off a launch edge");
    a_bypass_each: assert property (cw_reg[19] && de |-> pixel_launch)
        else $error("bypass launch missing");
    a_div_space: assert property (div_tick |-> since_reg == {cw_reg[9:0], 1'b1})
        else $error("launch spacing wrong");
    a_edge_sense: assert property (div_tick |->
        pixel_clock == cw_reg[17] ##1 pixel_clock != cw_reg[17])
        else $error("launch edge polarity wrong");
    a_sync_idle: assert property (de |-> panel_pins.line_clock == cw_reg[16]
        && panel_pins.frame_clock == cw_reg[15])
        else $error("sync active during pixels");
    c_pixel: cover property (pixel_launch && de);
    c_frame: cover property ($rose(panel_pins.frame_clock));
    c_unmapped: cover property (taken && !hit);
endmodule : lcd_panel_timing_chk

bind lcd_panel_timing_clock_gen lcd_panel_timing_chk #(.ADDR_WIDTH(ADDR_WIDTH)) i_chk (
    .clk(clk), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .panel_pins(panel_pins), .pixel_clock(pixel_clock), .pixel_launch(pixel_launch));

/* File: tb/panel_model.sv */
// Purpose: Passive panel measuring line and frame timing
// Assumes: Pins settle on the edge flagged by pixel_launch
// Notes:   m: act p1 sync p2 lines fsync alines bias per gap frames
`timescale 1ns/1ps
module panel_model (
    input  wire logic                  clk,
    input  wire logic                  rst_n,
    input  wire lcd_timing_pkg::panel_pins_type pins,
    input  wire logic                  pixel_clock,
    input  wire logic                  pixel_launch,
    input  wire logic                  lc_inv,
    input  wire logic                  fc_inv,
    output logic [10:0][7:0]           m
);
    import lcd_timing_pkg::*;
    logic       tick, lc_d, fc_d, de_d, bias_d, pc_d;
    logic [1:0] st, pv;
    logic [7:0] run, lines, alines, fcl, bl, per, gap;
    wire        lc = pins.line_clock ^ lc_inv;
    wire        fc = pins.frame_clock ^ fc_inv;
    wire        lc_up = lc && !lc_d;
    wire  [1:0] s = {pins.data_enable, lc};
    always @(posedge clk)
    begin
        {tick, lc_d, fc_d, de_d, bias_d, pc_d} <= {pixel_launch, lc, fc,
            pins.data_enable, pins.bias, pixel_clock};
        if (!rst_n)
        begin
            m <= '0;
            st <= 2'h0;
        end
        else
        begin
            gap <= pixel_launch ? 8'h01 : gap + 8'h01;
            if (pixel_launch) m[9] <= gap;
            per <= (pixel_clock && !pc_d) ? 8'h01 : per + 8'h01;
            if (pixel_clock && !pc_d) m[8] <= per;
            // Phase runs, in launches
            if (tick && s != st && st == 2'b10) m[0] <= run;
            if (tick && s != st && st == 2'b01) m[2] <= run;
            if (tick && st == 2'b00 && s == 2'b01 && pv == 2'b10) m[1] <= run;
            if (tick && st == 2'b00 && s == 2'b10) m[3] <= run;
            if (tick) run <= (s != st) ? 8'h01 : run + 8'h01;
            if (tick) st <= s;
            if (tick && s != st) pv <= st;
            if (lc_up) lines <= lines + 8'h01;
            if (lc_up) bl <= bl + 8'h01;
            if (lc_up && fc) fcl <= fcl + 8'h01;
            if (pins.data_enable && !de_d) alines <= alines + 8'h01;
            if (pins.bias != bias_d)
            begin
                m[7] <= bl;
                bl <= 8'h00;
            end
            if (fc && !fc_d)
            begin
                m[4] <= lines;
                m[6] <= alines;
                m[10] <= m[10] + 8'h01;
                {lines, alines, fcl} <= '0;
            end
            if (!fc && fc_d) m[5] <= fcl;
        end
    end
endmodule : panel_model

/* File: tb/testbench.sv */
// Purpose: Register and panel timing tests over Wishbone
// Assumes: One request at a time
// Notes:   Small spans keep each frame short
`timescale 1ns/1ps
module testbench;
    import lcd_timing_pkg::*;
    logic             clk, rst_n, cyc, stb, we, ack, pclk, launch;
    logic [7:0]       adr;
    logic [3:0]       sel;
    logic [31:0]      wdat, rdat, q, cfg;
    logic [10:0][7:0] m;
    panel_pins_type   pins;
    int               n_fail, num_checks;
    logic [7:0]       offs [4] = '{OFFSET_HORIZ, OFFSET_VERT, OFFSET_CLOCK, 8'h08};

    lcd_panel_timing_clock_gen #(.ADDR_WIDTH(8)) i_lcd_panel_timing_clock_gen (
        .clk(clk), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .panel_pins(pins), .pixel_clock(pclk), .pixel_launch(launch));
    panel_model i_panel_model (.clk(clk), .rst_n(rst_n), .pins(pins), .pixel_clock(pclk),
        .pixel_launch(launch), .lc_inv(cfg[16]), .fc_inv(cfg[15]), .m(m));

    task report_and_stop();
        if (n_fail == 0 && num_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : report_and_stop

    task chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            n_fail++;
            $display("[ERR] %0t got %h want %h", $time, got, exp);
        end
    endtask : chk

    task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        {cyc, stb, we, adr, wdat} <= {2'b11, w, a, d};
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 20);
        q = rdat;
        chk({31'h0, ack}, 32'h1);
        {cyc, stb, we} <= 3'b000;
        @(posedge clk);
    endtask : bus

    task rd(input logic [7:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        chk(q, exp);
    endtask : rd

    task chk_m(input logic [9:0][7:0] e);
        for (int i = 0; i < 10; i++)
            if (e[i] !== 8'h00)
                chk({24'h0, m[i]}, {24'h0, e[i]});
    endtask : chk_m

    // Waits three frame starts
    task run(input logic [31:0] cw, input logic [31:0] ctl);
        logic [7:0] f0;
        int n;
        cfg <= cw;
        bus(1'b1, OFFSET_CLOCK, cw);
        bus(1'b1, OFFSET_CONTROL, ctl);
        f0 = m[10];
        n = 0;
        while (8'(m[10] - f0) < 8'h03 && n < 3000)
        begin
            @(posedge clk);
            n++;
        end
    endtask : run

    task halt(input logic [31:0] ctl);
        int n;
        bus(1'b1, OFFSET_CONTROL, ctl & 32'hFFFF_FFFE);
        n = 0;
        do
        begin
            bus(1'b0, OFFSET_STATUS, 32'h0);
            n++;
        end while (q[STAT_SHUT_BIT] !== 1'b1 && n < 300);
        chk(q & 32'h81, 32'h80);
        bus(1'b1, OFFSET_STATUS, 32'h80);
        rd(OFFSET_STATUS, 32'h0);
    endtask : halt

    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    initial
    begin
        repeat (40000) @(posedge clk);
        n_fail++;
        $display("[ERR] %0t timeout", $time);
        report_and_stop();
    end

    initial
    begin
        {cyc, stb, we, adr, wdat, cfg, rst_n} = '0;
        sel = 4'hF;
        n_fail = 0;
        num_checks = 0;
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        for (int i = 0; i < 4; i++) rd(offs[i], 32'h0);
        bus(1'b1, OFFSET_CLOCK, 32'hFFFF_FFFF);
        rd(OFFSET_CLOCK, CLOCK_MASK);
        bus(1'b1, 8'h08, 32'hFFFF_FFFF);
        rd(8'h08, 32'h0);
        bus(1'b1, OFFSET_HORIZ, 32'h0201_0803);
        bus(1'b1, OFFSET_VERT, 32'h0102_0401);
        rd(OFFSET_HORIZ, 32'h0201_0803);
        rd(OFFSET_VERT, 32'h0102_0401);
        run(32'h0005_0001, 32'h3);
        chk({31'h0, pins.bias}, 32'h1);
        bus(1'b1, OFFSET_HORIZ, 32'h0);
        rd(OFFSET_HORIZ, 32'h0201_0803);
        chk_m(80'h04_04_00_02_02_09_03_03_02_04);
        halt(32'h3);
        run(32'h0002_8401, 32'h1);
        chk_m(80'h04_04_02_02_01_05_03_03_02_04);
        halt(32'h1);
        run(32'h0008_0000, 32'h3);
        chk_m(80'h01_00_00_02_02_09_03_03_02_04);
        halt(32'h3);
        report_and_stop();
    end
endmodule : testbench
